/* dip_dispatch.v */
// Dual-issue dispatch and five-stage integer pipeline control
// What this block does
// - Issue at most two instructions per cycle
// - Classify each instruction into one of four
// - Function and memory pipes accept their classes
// - Dual issue only one per pipe
// - Five stages, register commit only at write
// - Floating-point depth hidden from the pipeline
// - Up to ten instructions in flight
// - Long operations may complete out of order
// - Fetch spans cache access, address translation
// - Read stage: registers, bypass, decode, target
// - Execute start: issue, branch, data address
// - Execute: integer ops and store align
// - Data stage: cache access, translate, align
// - Register write in write stage
// - Bubbles fill slots lost to hazards
// - Multiply, divide and moves use function pipe
// - Add, logic and shift take one cycle
// - One-cycle load delay; autonomous multiply unit
// - Multiply-accumulate and three-operand multiply provided
// - 32 64-bit registers, result pair, no flags
// - Only 29 and 5 system slots implemented
// - Zero register always reads zero
// - Four read, two write ports, full bypass
`timescale 1ns/1ps
`include "dip_map.vh"

module dip_dispatch (
    // Clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // Instruction cache
    output wire        icReq,
    output reg  [63:0] icAddr_q,
    input  wire        icValid,
    input  wire [31:0] icData0,
    input  wire [31:0] icData1,
    // Data cache
    output wire        dcReq,
    output wire        dcWe,
    output wire [63:0] dcAddr,
    output wire [7:0]  dcBe,
    output wire [63:0] dcWdata,
    input  wire [63:0] dcRdata,
    // Floating-point hand-off
    output wire        fpValid,
    output wire [31:0] fpIns,
    // Status
    output wire [1:0]  issueCnt,
    output wire        slipR,
    output reg  [3:0]  inFlight,
    output wire        mulBusy,
    output wire [31:0] sysCtlImpl0,
    output wire [31:0] sysCtlImpl1
);

    localparam F = `DIP_PIPE_F;
    localparam M = `DIP_PIPE_M;

    function [1:0] insClass(input [31:0] i);
        begin
            case (i[`DIP_F_OP])
                `DIP_OP_LD, `DIP_OP_SD, `DIP_OP_LW, `DIP_OP_SW:
                    insClass = `DIP_CL_LS;
                `DIP_OP_BEQ, `DIP_OP_BNE, `DIP_OP_JMP:
                    insClass = `DIP_CL_BR;
                `DIP_OP_FPOP:
                    insClass = `DIP_CL_FP;
                default:
                    insClass = `DIP_CL_INT;
            endcase
        end
    endfunction

    function isMulDiv(input [31:0] i);
        begin
            isMulDiv = i[`DIP_F_OP] >= `DIP_OP_MULT &&
                       i[`DIP_F_OP] <= `DIP_OP_MOVE_LOWER_RESULT_OP;
        end
    endfunction

    function isMulStart(input [31:0] i);
        begin
            isMulStart = i[`DIP_F_OP] == `DIP_OP_MULT ||
                         i[`DIP_F_OP] == `DIP_OP_DIV ||
                         i[`DIP_F_OP] == `DIP_OP_MADD;
        end
    endfunction

    function fOnly(input [31:0] i);
        begin
            fOnly = isMulDiv(i) || insClass(i) == `DIP_CL_BR ||
                    insClass(i) == `DIP_CL_FP;
        end
    endfunction

    function isLoad(input [31:0] i);
        begin
            isLoad = i[`DIP_F_OP] == `DIP_OP_LD ||
                     i[`DIP_F_OP] == `DIP_OP_LW;
        end
    endfunction

    // Destination register, zero when nothing is written
    function [4:0] dest(input [31:0] i);
        reg w;
        begin
            case (i[`DIP_F_OP])
                `DIP_OP_ADD, `DIP_OP_SUB, `DIP_OP_AND, `DIP_OP_OR,
                `DIP_OP_XOR, `DIP_OP_SLL, `DIP_OP_SRL, `DIP_OP_ADDI,
                `DIP_OP_LD, `DIP_OP_LW, `DIP_OP_MUL3, `DIP_OP_MFUP,
                `DIP_OP_MOVE_LOWER_RESULT_OP: w = 1'b1;
                default:      w = 1'b0;
            endcase
            dest = w ? i[`DIP_F_RD] : 5'h00;
        end
    endfunction

    // Conservative source check against register r
    function reads(input [31:0] i, input [4:0] r);
        reg u;
        begin
            case (i[`DIP_F_OP])
                `DIP_OP_NOP, `DIP_OP_JMP, `DIP_OP_FPOP: u = 1'b0;
                default:                                u = 1'b1;
            endcase
            reads = u && r != 5'h00 &&
                    (i[`DIP_F_RS] == r || i[`DIP_F_RT] == r);
        end
    endfunction

    function [63:0] sext(input [31:0] i);
        begin
            sext = {{53{i[`DIP_IMM_SIGN]}}, i[`DIP_F_IMM]};
        end
    endfunction

    function [63:0] alu(input [31:0] i, input [63:0] a, input [63:0] b);
        begin
            case (i[`DIP_F_OP])
                `DIP_OP_ADD: alu = a + b;
                `DIP_OP_SUB: alu = a - b;
                `DIP_OP_AND: alu = a & b;
                `DIP_OP_OR:  alu = a | b;
                `DIP_OP_XOR: alu = a ^ b;
                `DIP_OP_SLL: alu = a << b[5:0];
                `DIP_OP_SRL: alu = a >> b[5:0];
                `DIP_OP_ADDI, `DIP_OP_LD, `DIP_OP_SD, `DIP_OP_LW,
                `DIP_OP_SW:  alu = a + sext(i);
                default:     alu = 64'h0000000000000000;
            endcase
        end
    endfunction

    // Read stage pair buffer
    reg        rVal0_q, rVal1_q;
    reg [31:0] rIns0_q, rIns1_q;
    reg [63:0] rPc_q;
    // Execute, data and write stages, one entry per pipe
    reg        aVal_q [0:1];
    reg [31:0] aIns_q [0:1];
    reg [63:0] aOpA_q [0:1];
    reg [63:0] aOpB_q [0:1];
    reg [63:0] aTgt_q [0:1];
    reg        dVal_q [0:1];
    reg [31:0] dIns_q [0:1];
    reg [63:0] dRes_q [0:1];
    reg [63:0] dSt_q;
    reg [7:0]  dBe_q;
    reg        wVal_q [0:1];
    reg [4:0]  wRd_q [0:1];
    reg [63:0] wRes_q [0:1];
    // Multiply/divide unit
    reg [63:0] upper_q, lower_q, pendUp_q, pendLo_q;
    reg [6:0]  mulCnt_q;

    wire [63:0] aRes [0:1];
    wire [63:0] dOut [0:1];
    wire [63:0] rfData [0:3];
    reg  [63:0] src [0:3];
    wire [4:0]  srcIdx [0:3];
    integer k, p, s, j;

    assign srcIdx[0] = rIns0_q[`DIP_F_RS];
    assign srcIdx[1] = rIns0_q[`DIP_F_RT];
    assign srcIdx[2] = rIns1_q[`DIP_F_RS];
    assign srcIdx[3] = rIns1_q[`DIP_F_RT];

    // four read and two write ports
    dip_regfile uRegs (
        .clk     (clk),
        .rdAddr0 (srcIdx[0]),
        .rdAddr1 (srcIdx[1]),
        .rdAddr2 (srcIdx[2]),
        .rdAddr3 (srcIdx[3]),
        .rdData0 (rfData[0]),
        .rdData1 (rfData[1]),
        .rdData2 (rfData[2]),
        .rdData3 (rfData[3]),
        .wrEn0   (wVal_q[F]),
        .wrAddr0 (wRd_q[F]),
        .wrData0 (wRes_q[F]),
        .wrEn1   (wVal_q[M]),
        .wrAddr1 (wRd_q[M]),
        .wrData1 (wRes_q[M])
    );

    // Product is shared by the accumulate, plain and three-operand forms
    wire [127:0] prod = {64'h0, aOpA_q[F]} * {64'h0, aOpB_q[F]};
    wire [127:0] macc = {upper_q, lower_q} + prod;
    wire [63:0]  quo  = (aOpB_q[F] == 64'h0) ? 64'h0 : aOpA_q[F] / aOpB_q[F];
    wire [63:0]  rem  = (aOpB_q[F] == 64'h0) ? 64'h0 : aOpA_q[F] % aOpB_q[F];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gPipe
            wire [5:0] aOp = aIns_q[g][`DIP_F_OP];
            wire [5:0] dOp = dIns_q[g][`DIP_F_OP];
            wire [31:0] ldWord = dRes_q[g][2] ? dcRdata[63:32]
                                              : dcRdata[31:0];
            assign aRes[g] =
                (g == F && aOp == `DIP_OP_MUL3) ? prod[63:0] :
                (g == F && aOp == `DIP_OP_MFUP) ? upper_q :
                (g == F && aOp == `DIP_OP_MOVE_LOWER_RESULT_OP) ? lower_q :
                alu(aIns_q[g], aOpA_q[g], aOpB_q[g]);
            // load alignment in the data stage
            assign dOut[g] = (g == M && dOp == `DIP_OP_LW) ?
                                 {{32{ldWord[31]}}, ldWord} :
                             (g == M && dOp == `DIP_OP_LD) ? dcRdata :
                             dRes_q[g];
        end
    endgenerate

    // bypass selection; execute results override older data stage
    always @* begin
        for (k = 0; k < 4; k = k + 1) begin
            src[k] = rfData[k];
            for (p = 0; p < 2; p = p + 1) begin
                if (wVal_q[p] && wRd_q[p] == srcIdx[k]) begin
                    src[k] = wRes_q[p];
                end
            end
            for (p = 0; p < 2; p = p + 1) begin
                if (dVal_q[p] && dest(dIns_q[p]) == srcIdx[k] &&
                    srcIdx[k] != 5'h00) begin
                    src[k] = dOut[p];
                end
            end
            for (p = 0; p < 2; p = p + 1) begin
                if (aVal_q[p] && !isLoad(aIns_q[p]) &&
                    dest(aIns_q[p]) == srcIdx[k] &&
                    srcIdx[k] != 5'h00) begin
                    src[k] = aRes[p];
                end
            end
        end
    end

    wire [5:0] brOp  = aIns_q[F][`DIP_F_OP];
    wire       brEq  = aOpA_q[F] == aOpB_q[F];
    wire       flush = aVal_q[F] && ((brOp == `DIP_OP_BEQ && brEq) ||
                       (brOp == `DIP_OP_BNE && !brEq) ||
                       brOp == `DIP_OP_JMP);

    // slip behind a load still one stage ahead
    wire [4:0] loadRd = (aVal_q[M] && isLoad(aIns_q[M])) ?
                        dest(aIns_q[M]) : 5'h00;
    // multiply unit busy holds its own family only
    wire mulHold = mulBusy || (aVal_q[F] && isMulStart(aIns_q[F]));
    wire haz0 = reads(rIns0_q, loadRd) || (isMulDiv(rIns0_q) && mulHold);
    wire haz1 = reads(rIns1_q, loadRd) || (isMulDiv(rIns1_q) && mulHold);

    // pipe choice: memory-only goes M, int yields F to a partner
    wire mOnly0 = insClass(rIns0_q) == `DIP_CL_LS;
    wire mOnly1 = insClass(rIns1_q) == `DIP_CL_LS;
    wire sel0   = mOnly0 || (fOnly(rIns1_q) && !fOnly(rIns0_q));
    wire fits1  = sel0 ? !mOnly1 : !fOnly(rIns1_q);
    wire [4:0] wr0 = dest(rIns0_q);

    wire issue0 = rVal0_q && !haz0 && !flush;
    // second slot only to the other pipe
    wire issue1 = issue0 && rVal1_q && fits1 && !haz1 &&
                  !reads(rIns1_q, wr0) &&
                  !(wr0 != 5'h00 && dest(rIns1_q) == wr0);
    assign issueCnt = {issue0 && issue1, issue0 ^ issue1};
    assign slipR = rVal0_q && !issue0;

    wire refill = !rVal0_q || (issue0 && (issue1 || !rVal1_q));
    // cache access and identity translation in fetch
    assign icReq = refill && !flush;

    // branch target from the read stage
    wire [63:0] pc1  = rPc_q + `DIP_INS_STEP;
    wire [63:0] off0 = sext(rIns0_q) << 2;
    wire [63:0] off1 = sext(rIns1_q) << 2;
    wire [63:0] tgt0 = pc1 + off0;
    wire [63:0] tgt1 = pc1 + `DIP_INS_STEP + off1;

    always @(posedge clk) begin
        if (sys_rst) begin
            icAddr_q <= `DIP_RESET_PC;
            rPc_q    <= `DIP_RESET_PC;
            rVal0_q  <= 1'b0;
            rVal1_q  <= 1'b0;
            rIns0_q  <= 32'h00000000;
            rIns1_q  <= 32'h00000000;
        end else if (flush) begin
            icAddr_q <= aTgt_q[F];
            rVal0_q  <= 1'b0;
            rVal1_q  <= 1'b0;
        end else if (refill) begin
            rVal0_q <= icValid;
            rVal1_q <= icValid;
            if (icValid) begin
                rIns0_q  <= icData0;
                rIns1_q  <= icData1;
                rPc_q    <= icAddr_q;
                icAddr_q <= icAddr_q + `DIP_FETCH_STEP;
            end
        end else if (issue0) begin
            rIns0_q <= rIns1_q;
            rPc_q   <= pc1;
            rVal1_q <= 1'b0;
        end
    end

    // five stages: fetch, read, execute, data, write
    always @(posedge clk) begin
        for (s = 0; s < 2; s = s + 1) begin
            if (sys_rst) begin
                aVal_q[s] <= 1'b0;
                dVal_q[s] <= 1'b0;
                wVal_q[s] <= 1'b0;
                aIns_q[s] <= 32'h00000000;
                dIns_q[s] <= 32'h00000000;
                wRd_q[s]  <= 5'h00;
            end else begin
                aVal_q[s] <= (issue0 && sel0 == s) ||
                             (issue1 && sel0 != s);
                if (issue0 && sel0 == s) begin
                    aIns_q[s] <= rIns0_q;
                    aOpA_q[s] <= src[0];
                    aOpB_q[s] <= src[1];
                    aTgt_q[s] <= tgt0;
                end else if (issue1 && sel0 != s) begin
                    aIns_q[s] <= rIns1_q;
                    aOpA_q[s] <= src[2];
                    aOpB_q[s] <= src[3];
                    aTgt_q[s] <= tgt1;
                end else begin
                    aIns_q[s] <= 32'h00000000;
                end
                dVal_q[s] <= aVal_q[s];
                dIns_q[s] <= aIns_q[s];
                dRes_q[s] <= aRes[s];
                wVal_q[s] <= dVal_q[s] && dest(dIns_q[s]) != 5'h00;
                wRd_q[s]  <= dest(dIns_q[s]);
                wRes_q[s] <= dOut[s];
            end
        end
    end

    wire [5:0] mOp  = aIns_q[M][`DIP_F_OP];
    wire       word = mOp == `DIP_OP_LW || mOp == `DIP_OP_SW;
    always @(posedge clk) begin
        if (sys_rst) begin
            dSt_q <= 64'h0000000000000000;
            dBe_q <= 8'h00;
        end else begin
            dSt_q <= word ? {aOpB_q[M][31:0], aOpB_q[M][31:0]} : aOpB_q[M];
            dBe_q <= !word ? 8'hFF : (aRes[M][2] ? 8'hF0 : 8'h0F);
        end
    end

    // data cache driven from the data stage
    wire [5:0] dmOp = dIns_q[M][`DIP_F_OP];
    assign dcReq   = dVal_q[M] && insClass(dIns_q[M]) == `DIP_CL_LS;
    assign dcWe    = dcReq && (dmOp == `DIP_OP_SD || dmOp == `DIP_OP_SW);
    assign dcAddr  = dRes_q[M];
    assign dcBe    = dBe_q;
    assign dcWdata = dSt_q;

    // accumulate and plain multiply, divide, autonomous
    always @(posedge clk) begin
        if (sys_rst) begin
            mulCnt_q <= 7'h00;
            upper_q  <= 64'h0000000000000000;
            lower_q  <= 64'h0000000000000000;
            pendUp_q <= 64'h0000000000000000;
            pendLo_q <= 64'h0000000000000000;
        end else if (aVal_q[F] && isMulStart(aIns_q[F])) begin
            case (brOp)
                `DIP_OP_DIV: begin
                    mulCnt_q <= `DIP_DIV_LAT;
                    pendUp_q <= rem;
                    pendLo_q <= quo;
                end
                `DIP_OP_MADD: begin
                    mulCnt_q <= `DIP_MUL_LAT;
                    pendUp_q <= macc[127:64];
                    pendLo_q <= macc[63:0];
                end
                default: begin
                    mulCnt_q <= `DIP_MUL_LAT;
                    pendUp_q <= prod[127:64];
                    pendLo_q <= prod[63:0];
                end
            endcase
        end else if (mulBusy) begin
            // result pair lands out of program order
            mulCnt_q <= mulCnt_q - 7'h01;
            if (mulCnt_q == 7'h01) begin
                upper_q <= pendUp_q;
                lower_q <= pendLo_q;
            end
        end
    end
    assign mulBusy = mulCnt_q != 7'h00;

    // floating-point work leaves after execute, no register write
    assign fpValid = aVal_q[F] && insClass(aIns_q[F]) == `DIP_CL_FP;
    assign fpIns   = aIns_q[F];

    // occupancy across fetch and the four pipe stages
    always @* begin
        inFlight = {3'h0, rVal0_q} + {3'h0, rVal1_q};
        if (icReq && icValid) begin
            inFlight = inFlight + 4'h2;
        end
        for (j = 0; j < 2; j = j + 1) begin
            inFlight = inFlight + {3'h0, aVal_q[j]} +
                       {3'h0, dVal_q[j]} + {3'h0, wVal_q[j]};
        end
    end

    assign sysCtlImpl0 = `DIP_SC0_IMPL;
    assign sysCtlImpl1 = `DIP_SC1_IMPL;

    // no condition flags exist; upper/lower pair above
endmodule // dip_dispatch

/* dip_dispatch_asserts.sv */
// Port checks for the dual-issue dispatch block
`timescale 1ns/1ps
`include "dip_map.vh"

module dip_dispatch_asserts (
    // Clock and reset
    input wire        clk,
    input wire        sys_rst,
    // Caches
    input wire        icReq,
    input wire        icValid,
    input wire [63:0] icAddr_q,
    input wire        dcReq,
    input wire        dcWe,
    input wire [7:0]  dcBe,
    input wire [63:0] dcWdata,
    // Status
    input wire        fpValid,
    input wire [31:0] fpIns,
    input wire [1:0]  issueCnt,
    input wire        slipR,
    input wire [3:0]  inFlight,
    input wire        mulBusy,
    input wire [31:0] sysCtlImpl0,
    input wire [31:0] sysCtlImpl1
);
    wire slotOk = sysCtlImpl0 == 32'h1FFFFFFF && sysCtlImpl1 == 32'h0000001F;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_pair_cap: assert property (issueCnt != 2'h3)
        else $error("issue count above two");
    a_flight_cap: assert property (inFlight <= 4'hA)
        else $error("more than ten in flight");
    a_slot_masks: assert property (slotOk)
        else $error("slot masks changed");
    a_fetch_step: assert property (icReq && icValid |=>
        icAddr_q == $past(icAddr_q) + 64'h8) else $error("fetch step wrong");
    a_store_lanes: assert property (dcReq && dcWe |-> dcBe == 8'hFF ||
        (dcBe == 8'hF0 || dcBe == 8'h0F) && dcWdata[63:32] == dcWdata[31:0])
        else $error("store lanes misaligned");
    a_fp_class: assert property (fpValid |->
        fpIns[`DIP_F_OP] == `DIP_OP_FPOP) else $error("non-fp handed off");
    a_slip_stalls: assert property (slipR |-> issueCnt == 2'h0)
        else $error("issue during slip");
    a_mul_hold: assert property ($rose(mulBusy) |-> mulBusy [*3])
        else $error("multiply busy too short");
    a_reset_fetch: assert property ($fell(sys_rst) |-> icReq &&
        icAddr_q == 64'h0 && issueCnt == 2'h0) else $error("bad reset state");

    c_dual: cover property (issueCnt == 2'h2);
    c_slip: cover property (slipR);
    c_fp: cover property (fpValid);
    c_mul: cover property ($rose(mulBusy));
    c_word_store: cover property (dcReq && dcWe && dcBe == 8'hF0);
endmodule // dip_dispatch_asserts

bind dip_dispatch dip_dispatch_asserts u_chk (.clk, .sys_rst, .icReq, .icValid,
    .icAddr_q, .dcReq, .dcWe, .dcBe, .dcWdata, .fpValid, .fpIns, .issueCnt,
    .slipR, .inFlight, .mulBusy, .sysCtlImpl0, .sysCtlImpl1);

/* dip_map.vh */
// Constants for the dual-issue dispatch and integer pipeline
`ifndef DIP_MAP_VH
`define DIP_MAP_VH

// Machine widths
`define DIP_XLEN        64
`define DIP_GREG_COUNT  32
`define DIP_RESET_PC    64'h0000000000000000
`define DIP_FETCH_STEP  64'h0000000000000008
`define DIP_INS_STEP    64'h0000000000000004

// Instruction fields
`define DIP_F_OP        31:26
`define DIP_F_RD        25:21
`define DIP_F_RS        20:16
`define DIP_F_RT        15:11
`define DIP_F_IMM       10:0
`define DIP_IMM_SIGN    10

// Opcodes
`define DIP_OP_NOP      6'h00
`define DIP_OP_ADD      6'h01
`define DIP_OP_SUB      6'h02
`define DIP_OP_AND      6'h03
`define DIP_OP_OR       6'h04
`define DIP_OP_XOR      6'h05
`define DIP_OP_SLL      6'h06
`define DIP_OP_SRL      6'h07
`define DIP_OP_LD       6'h08
`define DIP_OP_SD       6'h09
`define DIP_OP_LW       6'h0A
`define DIP_OP_SW       6'h0B
`define DIP_OP_BEQ      6'h0C
`define DIP_OP_BNE      6'h0D
`define DIP_OP_JMP      6'h0E
`define DIP_OP_FPOP     6'h0F
`define DIP_OP_MULT     6'h10
`define DIP_OP_DIV      6'h11
`define DIP_OP_MADD     6'h12
`define DIP_OP_MUL3     6'h13
`define DIP_OP_MFUP     6'h14
`define DIP_OP_MOVE_LOWER_RESULT_OP     6'h15
`define DIP_OP_ADDI     6'h16

// Issue classes
`define DIP_CL_INT      2'h0
`define DIP_CL_LS       2'h1
`define DIP_CL_BR       2'h2
`define DIP_CL_FP       2'h3

// Logical pipes
`define DIP_PIPE_F      0
`define DIP_PIPE_M      1

// Multiply/divide unit latencies in cycles
`define DIP_MUL_LAT     7'h05
`define DIP_DIV_LAT     7'h24

// Implemented system-control register slots per set
`define DIP_SC0_IMPL    32'h1FFFFFFF
`define DIP_SC1_IMPL    32'h0000001F

`endif

/* dip_regfile.v */
// General register file: four read ports, two write ports
`timescale 1ns/1ps
`include "dip_map.vh"

module dip_regfile (
    // Clock
    input  wire        clk,
    // Read ports
    input  wire [4:0]  rdAddr0,
    input  wire [4:0]  rdAddr1,
    input  wire [4:0]  rdAddr2,
    input  wire [4:0]  rdAddr3,
    output reg  [63:0] rdData0,
    output reg  [63:0] rdData1,
    output reg  [63:0] rdData2,
    output reg  [63:0] rdData3,
    // Write ports
    input  wire        wrEn0,
    input  wire [4:0]  wrAddr0,
    input  wire [63:0] wrData0,
    input  wire        wrEn1,
    input  wire [4:0]  wrAddr1,
    input  wire [63:0] wrData1
);

    reg [63:0] regs_q [0:`DIP_GREG_COUNT-1];

    // Write-through so a result in write-back is seen by the read stage
    function [63:0] rdPort(input [4:0] a, input [63:0] mem);
        begin
            if (a == 5'h00) begin
                rdPort = 64'h0000000000000000;
            end else if (wrEn1 && wrAddr1 == a) begin
                rdPort = wrData1;
            end else if (wrEn0 && wrAddr0 == a) begin
                rdPort = wrData0;
            end else begin
                rdPort = mem;
            end
        end
    endfunction

    always @* begin
        rdData0 = rdPort(rdAddr0, regs_q[rdAddr0]);
        rdData1 = rdPort(rdAddr1, regs_q[rdAddr1]);
        rdData2 = rdPort(rdAddr2, regs_q[rdAddr2]);
        rdData3 = rdPort(rdAddr3, regs_q[rdAddr3]);
    end

    always @(posedge clk) begin
        if (wrEn0 && wrAddr0 != 5'h00) begin
            regs_q[wrAddr0] <= wrData0;
        end
        if (wrEn1 && wrAddr1 != 5'h00) begin
            regs_q[wrAddr1] <= wrData1;
        end
    end

endmodule // dip_regfile

/* dual_issue_pipeline_dispatch_tb_top.sv */
// Self-checking bench for the dual-issue dispatch block
`timescale 1ns/1ps
`include "dip_map.vh"

module dual_issue_pipeline_dispatch_tb_top;
    reg          clk, sys_rst, icValid;
    reg  [31:0]  icData0, icData1;
    reg  [63:0]  dcRdata;
    wire         icReq, dcReq, dcWe, fpValid, slipR, mulBusy;
    wire [63:0]  icAddr_q, dcAddr, dcWdata;
    wire [7:0]   dcBe;
    wire [31:0]  fpIns, sysCtlImpl0, sysCtlImpl1;
    wire [1:0]   issueCnt;
    wire [3:0]   inFlight;
    integer      bad_count, n_compared, fpSeen, fpWant, i, k, t;
    reg  [31:0]  seed, prog [0:255];
    reg  [63:0]  gr [0:31];
    reg  [63:0]  upR, loR, pc;
    reg  [136:0] expQ [$];
    reg  [136:0] e;

    dip_dispatch dut (.clk, .sys_rst, .icReq, .icAddr_q, .icValid, .icData0,
        .icData1, .dcReq, .dcWe, .dcAddr, .dcBe, .dcWdata, .dcRdata, .fpValid,
        .fpIns, .issueCnt, .slipR, .inFlight, .mulBusy, .sysCtlImpl0,
        .sysCtlImpl1);

    function automatic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic [31:0] fw(input [63:0] a);
        return (a[63:10] == 54'h0) ? prog[a[9:2]] : 32'h0;
    endfunction

    // Data cache stand-in: every address holds a value derived from itself
    function automatic [63:0] ldv(input [63:0] a);
        return {a[31:0] ^ 32'h5A5AC3C3, ~a[31:0]};
    endfunction

    task chk(input [63:0] got, input [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Sequential reference: one instruction at a time, in program order
    task automatic run1(input [31:0] w);
        reg [63:0]  a, b, r, sx;
        reg [127:0] p;
        reg         wr;
        a = gr[w[`DIP_F_RS]];
        b = gr[w[`DIP_F_RT]];
        sx = {{53{w[`DIP_IMM_SIGN]}}, w[`DIP_F_IMM]};
        p = {64'h0, a} * {64'h0, b};
        r = 64'h0;
        wr = 1'b1;
        pc = pc + 64'h4;
        case (w[`DIP_F_OP])
            `DIP_OP_ADD: r = a + b;
            `DIP_OP_SUB: r = a - b;
            `DIP_OP_AND: r = a & b;
            `DIP_OP_OR: r = a | b;
            `DIP_OP_XOR: r = a ^ b;
            `DIP_OP_SLL: r = a << b[5:0];
            `DIP_OP_SRL: r = a >> b[5:0];
            `DIP_OP_ADDI: r = a + sx;
            `DIP_OP_LD: r = ldv(a + sx);
            `DIP_OP_LW: begin
                r = ldv(a + sx);
                r = sx[2] ? {{32{r[63]}}, r[63:32]} : {{32{r[31]}}, r[31:0]};
            end
            `DIP_OP_SD: expQ.push_back({1'b1, a + sx, 8'hFF, b});
            `DIP_OP_SW: expQ.push_back({1'b1, a + sx,
                sx[2] ? 8'hF0 : 8'h0F, {2{b[31:0]}}});
            `DIP_OP_MULT: {upR, loR} = p;
            `DIP_OP_MADD: {upR, loR} = {upR, loR} + p;
            `DIP_OP_DIV: {upR, loR} = (b == 64'h0) ? 128'h0 : {a % b, a / b};
            `DIP_OP_MUL3: r = p[63:0];
            `DIP_OP_MFUP: r = upR;
            `DIP_OP_MOVE_LOWER_RESULT_OP: r = loR;
            `DIP_OP_FPOP: fpWant++;
            `DIP_OP_BEQ: if (a == b) pc = pc + (sx << 2);
            `DIP_OP_BNE: if (a != b) pc = pc + (sx << 2);
            `DIP_OP_JMP: pc = pc + (sx << 2);
            default: wr = 1'b0;
        endcase
        if (w[`DIP_F_OP] == `DIP_OP_LD || w[`DIP_F_OP] == `DIP_OP_LW)
            expQ.push_back({1'b0, a + sx, 72'h0});
        if (w[`DIP_F_OP] >= `DIP_OP_SD && w[`DIP_F_OP] != `DIP_OP_LW
            && w[`DIP_F_OP] <= `DIP_OP_MADD)
            wr = w[`DIP_F_OP] == `DIP_OP_LW;
        if (wr && w[`DIP_F_RD] != 5'h0)
            gr[w[`DIP_F_RD]] = r;
    endtask

    // Random program: seeded registers, mixed body, stores of r0..r7 last
    task automatic build();
        integer     n;
        reg [31:0]  r;
        reg [5:0]   op;
        reg [10:0]  im;
        for (n = 0; n < 256; n++)
            prog[n] = 32'h0;
        for (n = 1; n < 8; n++) begin
            r = xs();
            prog[n - 1] = {`DIP_OP_ADDI, n[4:0], 10'h0, r[10:0]};
        end
        n = 7;
        while (n < 200) begin
            r = xs();
            op = r % 22;
            im = r[31:21];
            if (op >= 6'd19) begin
                prog[n] = {6'h0C + op - 6'd19, 15'h0, 11'h2};
                n = n + 2;
            end else begin
                op = (op < 6'd11) ? op + 6'd1 : op + 6'd4;
                if (op >= `DIP_OP_LD && op <= `DIP_OP_SW)
                    im = {2'h0, r[27:22], op[1] & r[28], 2'h0};
                prog[n] = {op, 2'h0, r[10:8], 2'h0,
                    (op >= `DIP_OP_LD && op <= `DIP_OP_SW) ? 3'h0 : r[13:11],
                    2'h0, r[16:14], im};
                n = n + 1;
            end
        end
        for (n = 0; n < 8; n++)
            prog[202 + n] = {`DIP_OP_SD, 12'h0, n[2:0], 11'h300 + {n[7:0], 3'h0}};
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @* begin
        icData0 = fw(icAddr_q);
        icData1 = fw(icAddr_q + `DIP_INS_STEP);
        dcRdata = ldv(dcAddr);
    end

    // Fetch answers arrive with random gaps
    always @(posedge clk)
        icValid <= (xs() & 32'h3) != 32'h0;

    always @(posedge clk) begin
        if (!sys_rst && fpValid)
            fpSeen++;
        if (!sys_rst && dcReq) begin
            e = (expQ.size() != 0) ? expQ.pop_front() : {1'b1, 136'h0};
            chk({63'h0, dcWe}, {63'h0, e[136]});
            chk(dcAddr, e[135:72]);
            if (e[136]) begin
                chk({56'h0, dcBe}, {56'h0, e[71:64]});
                chk(dcWdata, e[63:0]);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        seed = 32'd72305;
        bad_count = 0;
        n_compared = 0;
        for (t = 0; t < 2; t++) begin
            sys_rst <= 1'b1;
            build();
            for (i = 0; i < 32; i++)
                gr[i] = 64'h0;
            {upR, loR, pc} = 192'h0;
            fpWant = 0;
            fpSeen = 0;
            expQ.delete();
            while (pc < 64'h400)
                run1(fw(pc));
            repeat (6) @(posedge clk);
            sys_rst <= 1'b0;
            #1;
            chk(icAddr_q, `DIP_RESET_PC);
            chk({sysCtlImpl0, sysCtlImpl1}, {32'h1FFFFFFF, 32'h0000001F});
            for (k = 0; k < 4000 && expQ.size() != 0; k++)
                @(posedge clk);
            repeat (40) @(posedge clk);
            chk(expQ.size(), 64'h0);
            chk(fpSeen, fpWant);
            $display("random program %0d done", t);
        end
        report_and_stop();
    end
endmodule // dual_issue_pipeline_dispatch_tb_top
